// file: core/lsw_pkg.sv
// Package for the LIN sleep, wake and error control block.
// Assumes a 250 MHz aclk; all counts are derived from that rate.
package lsw_pkg;

  localparam int unsigned CLK_MHZ = 250;

  // AXI4-Lite register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERROR  = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;

  // Control register fields
  localparam int CTRL_HALT_BIT    = 7;
  localparam int CTRL_DORMANT_BIT = 6;
  localparam int CTRL_DACK_BIT    = 4;
  localparam int CTRL_CLRERR_BIT  = 2;
  localparam int CTRL_WAKE_BIT    = 1;
  localparam int CTRL_MASTER_BIT  = 8;
  localparam int CTRL_CSUM_BIT    = 9;
  localparam int CTRL_START_BIT   = 10;

  // Status register fields
  localparam int ST_DONE_BIT  = 0;
  localparam int ST_WAKE_BIT  = 1;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_IDLE_BIT  = 6;

  // Error register fields
  localparam int ERR_FRAME_BIT = 0;
  localparam int ERR_RESPONSE_TIMEOUT_ERROR_BIT  = 2;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;

  // Timing figures and the cycle counts derived from them
  localparam int unsigned IDLE_TIMEOUT_S    = 4;
  localparam int unsigned WAKE_TIMEOUT_MS   = 150;
  localparam int unsigned IDLE_CYCLES       = IDLE_TIMEOUT_S * 1000000 * CLK_MHZ;
  localparam int unsigned WAKE_RESP_CYCLES  = WAKE_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned WAKE_PULSE_US     = 250;
  localparam int unsigned WAKE_PULSE_CYCLES = WAKE_PULSE_US * CLK_MHZ;
  localparam int unsigned WAKE_DET_US       = 150;
  localparam int unsigned WAKE_DET_CYCLES   = WAKE_DET_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LSW_RESP_OKAY   = 2'b00,
    LSW_RESP_SLVERR = 2'b10
  } lsw_resp_t;

  typedef struct packed {
    logic master;
    logic csum;
    logic dormant;
  } lsw_cfg_t;

  typedef struct packed {
    logic frame_err;
    logic start_bit_err;
  } lsw_err_in_t;

endpackage

// file: core/lsw_counter.sv
// Timeout counter: counts while enabled, restarts on clear, pulses once at the limit.
// Assumes the limit is at least one.
`timescale 1ns/100ps
module lsw_counter #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic clear,
  input  wire logic enable,
  // Result
  output logic      hit
);
  localparam int W = $clog2(LIMIT + 1) > 0 ? $clog2(LIMIT + 1) : 1;
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         hit_d;

  assign hit_d = enable && !clear && (cnt_q == LIM - W'(1));
  assign cnt_d = (clear || !enable) ? '0 : (cnt_q == LIM) ? cnt_q : cnt_q + W'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      hit   <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hit   <= hit_d;
    end
  end
endmodule // lsw_counter

// file: core/lsw_ctrl.sv
// LIN sleep, wake and error control with an AXI4-Lite register slave.
// Assumes the frame engine reports errors and activity synchronous to aclk.
//
// Behaviour
// - After halt, the engine stops and master starts are refused until the next sync break arrives.
// - Changing checksum mode mid-transaction resets the interface, dropping the transaction.
// - Changing master/slave role mid-transaction likewise resets and drops the transaction.
// - Not dormant and four idle seconds: set idle-timeout flag and interrupt.
// - Setting wake request transmits a wake-up signal in either role.
// - Master: successful wake transmission sets transfer-complete and interrupts.
// - Slave: no interrupt on send; no answer in 150 ms sets fault, timeout.
// - A detected wake-up signal sets wake-detected and transfer-complete, interrupting.
// - Any detected error abandons the current frame and interrupts; the slave response timeout sets fault but does not reset the engine.
// - Writing clear-error wipes the error register and the fault flag together.
// - New master messages and wake-ups are refused while the fault flag is set.
`timescale 1ns/100ps
module lsw_ctrl #(
  parameter int unsigned IDLE_CYC  = lsw_pkg::IDLE_CYCLES,
  parameter int unsigned RESP_CYC  = lsw_pkg::WAKE_RESP_CYCLES,
  parameter int unsigned PULSE_CYC = lsw_pkg::WAKE_PULSE_CYCLES,
  parameter int unsigned DET_CYC   = lsw_pkg::WAKE_DET_CYCLES
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Bus transceiver
  input  wire logic             lin_rx,
  output logic                  lin_tx,
  // Frame engine
  input  wire logic             sync_break,
  input  wire logic             frame_busy,
  input  wire logic             master_resp,
  input  wire lsw_pkg::lsw_err_in_t err_in,
  output lsw_pkg::lsw_cfg_t     cfg,
  output logic                  engine_run,
  output logic                  engine_reset,
  output logic                  master_start,
  output logic                  data_acknowledge,
  // Interrupt
  output logic                  irq
);
  import lsw_pkg::*;

  typedef enum logic [1:0] {LSW_IDLE, LSW_SEND, LSW_WAIT} lsw_wake_t;

  lsw_wake_t   wst_q;
  lsw_wake_t   wst_d;
  logic [10:0] link_control_register;
  logic [7:0]  link_status_register;
  logic [7:0]  link_error_register;
  logic [7:0]  mask_q;
  logic        halted_q;
  logic        rx_q;
  logic        det_low_q;
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // Bus slave decode
  wire aw_take  = s_axi_awvalid && !aw_q && !s_axi_bvalid;
  wire w_take   = s_axi_wvalid && !w_q && !s_axi_bvalid;
  wire aw_have  = aw_q || aw_take;
  wire w_have   = w_q || w_take;
  wire wr_fire  = aw_have && w_have && !s_axi_bvalid;
  wire [7:0]  wa = aw_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_q ? wdata_q : s_axi_wdata;
  wire [3:0]  ws = w_q ? wstrb_q : s_axi_wstrb;
  wire wr_ctrl  = wr_fire && (wa == ADDR_CTRL);
  wire wr_stat  = wr_fire && (wa == ADDR_STATUS);
  wire wr_mask  = wr_fire && (wa == ADDR_MASK);
  wire wr_ok    = wr_ctrl || wr_stat || wr_mask || (wr_fire && (wa == ADDR_ERROR));
  wire lo_en    = ws[0];
  wire hi_en    = ws[1];
  wire ar_take  = s_axi_arvalid && !s_axi_rvalid;
  wire rd_ctrl  = s_axi_araddr == ADDR_CTRL;
  wire rd_stat  = s_axi_araddr == ADDR_STATUS;
  wire rd_err   = s_axi_araddr == ADDR_ERROR;
  wire rd_mask  = s_axi_araddr == ADDR_MASK;
  wire rd_ok    = rd_ctrl || rd_stat || rd_err || rd_mask;
  wire [31:0] rd_word = rd_ctrl ? {21'h000000, link_control_register} :
                        rd_stat ? {24'h000000, link_status_register} :
                        rd_err  ? {24'h000000, link_error_register} :
                        rd_mask ? {24'h000000, mask_q} : 32'h00000000;

  assign s_axi_awready = aw_take;
  assign s_axi_wready  = w_take;
  assign s_axi_arready = ar_take;

  // Control strobes written as one
  wire wb_halt   = wr_ctrl && lo_en && wd[CTRL_HALT_BIT];
  wire wb_dack   = wr_ctrl && lo_en && wd[CTRL_DACK_BIT];
  wire wb_clrerr = wr_ctrl && lo_en && wd[CTRL_CLRERR_BIT];
  wire wb_wake   = wr_ctrl && lo_en && wd[CTRL_WAKE_BIT];
  wire wb_start  = wr_ctrl && hi_en && wd[CTRL_START_BIT];
  wire fault     = link_status_register[ST_FAULT_BIT];

  // A changed checksum or role while a frame is under way drops it
  wire csum_chg  = wr_ctrl && hi_en && (wd[CTRL_CSUM_BIT] != link_control_register[CTRL_CSUM_BIT]);
  wire role_chg  = wr_ctrl && hi_en && (wd[CTRL_MASTER_BIT] != link_control_register[CTRL_MASTER_BIT]);
  wire cfg_reset = (csum_chg || role_chg) && frame_busy;
  wire is_master = link_control_register[CTRL_MASTER_BIT];

  // Receive line activity and wake detection
  wire rx_edge    = lin_rx != rx_q;
  wire low_hit;
  wire pulse_hit;
  wire resp_hit;
  wire idle_hit;
  wire wake_seen  = low_hit && (wst_q == LSW_IDLE);
  wire err_any    = err_in.frame_err || err_in.start_bit_err;

  // Wake transmit sequencer
  wire wake_go = wb_wake && !fault && (wst_q == LSW_IDLE);
  always_comb begin
    wst_d = wst_q;
    case (wst_q)
      LSW_IDLE: begin
        if (wake_go) begin
          wst_d = LSW_SEND;
        end
      end
      LSW_SEND: begin
        if (pulse_hit) begin
          wst_d = is_master ? LSW_IDLE : LSW_WAIT;
        end
      end
      LSW_WAIT: begin
        if (master_resp || sync_break || resp_hit) begin
          wst_d = LSW_IDLE;
        end
      end
      default: wst_d = LSW_IDLE;
    endcase
  end

  wire master_done = pulse_hit && (wst_q == LSW_SEND) && is_master;
  wire slave_response_timeout_error  = resp_hit && (wst_q == LSW_WAIT) && !master_resp && !sync_break;

  // Event sets win over software clears
  wire [7:0] st_set = {1'b0, idle_hit, 3'b000, slave_response_timeout_error || err_any, wake_seen, master_done || wake_seen};
  wire [7:0] st_clr = (wr_stat && lo_en) ? wd[7:0] : 8'h00;
  wire [7:0] st_clr_f = st_clr | (wb_clrerr ? (8'h01 << ST_FAULT_BIT) : 8'h00);
  wire [7:0] st_next = (link_status_register & ~st_clr_f) | st_set;
  wire [7:0] er_set = {5'b00000, slave_response_timeout_error, err_in.start_bit_err, err_in.frame_err};
  wire [7:0] er_next = (wb_clrerr ? 8'h00 : link_error_register) | er_set;

  lsw_counter #(.LIMIT(IDLE_CYC)) u_idle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (rx_edge),
    .enable  (!link_control_register[CTRL_DORMANT_BIT]),
    .hit     (idle_hit)
  );

  // The sequencer leaves on the registered hit, so the line stays low PULSE_CYC plus one cycles
  lsw_counter #(.LIMIT(PULSE_CYC)) u_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (1'b0),
    .enable  (wst_q == LSW_SEND),
    .hit     (pulse_hit)
  );

  lsw_counter #(.LIMIT(RESP_CYC)) u_resp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (1'b0),
    .enable  (wst_q == LSW_WAIT),
    .hit     (resp_hit)
  );

  lsw_counter #(.LIMIT(DET_CYC)) u_det (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (rx_edge),
    .enable  (!lin_rx && !det_low_q),
    .hit     (low_hit)
  );

  // Register slave and control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= LSW_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_q <= wr_fire ? 1'b0 : aw_have;
      w_q  <= wr_fire ? 1'b0 : w_have;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? LSW_RESP_OKAY : LSW_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= LSW_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? LSW_RESP_OKAY : LSW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_control_register <= 11'h000;
      mask_q                <= MASK_RESET;
    end else begin
      if (wr_ctrl && lo_en) begin
        link_control_register[CTRL_DORMANT_BIT] <= wd[CTRL_DORMANT_BIT];
      end
      if (wr_ctrl && hi_en) begin
        link_control_register[CTRL_CSUM_BIT]   <= wd[CTRL_CSUM_BIT];
        link_control_register[CTRL_MASTER_BIT] <= wd[CTRL_MASTER_BIT];
      end
      if (wr_mask && lo_en) begin
        mask_q <= wd[7:0];
      end
    end
  end

  // Next values of the registered outputs
  wire halt_d  = sync_break ? 1'b0 : (halted_q || wb_halt);
  wire reset_d = cfg_reset || err_any;
  // Start follows the role being written; a halt in the same write wins
  wire start_d = wb_start && wd[CTRL_MASTER_BIT] && !fault && !halted_q && !wb_halt;
  wire dack_d  = wb_dack && !wb_halt;
  // Taken from wst_d so the line falls on the same edge the sequencer leaves idle
  wire tx_d    = !(wst_d == LSW_SEND);
  wire irq_d   = |(st_next & mask_q);

  // Sticky status and error words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_status_register <= STATUS_RESET;
      link_error_register  <= 8'h00;
    end else begin
      link_status_register <= st_next;
      link_error_register  <= er_next;
    end
  end

  // Wake sequencer and receive-line trackers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q     <= LSW_IDLE;
      rx_q      <= 1'b1;
      det_low_q <= 1'b0;
    end else begin
      wst_q     <= wst_d;
      rx_q      <= lin_rx;
      // One wake report per low stretch
      det_low_q <= lin_rx ? 1'b0 : (det_low_q || low_hit);
    end
  end

  // Halt holds until a sync break; a break in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halted_q <= 1'b0;
    end else begin
      halted_q <= halt_d;
    end
  end

  // Engine strobes, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      engine_reset     <= 1'b0;
      master_start     <= 1'b0;
      data_acknowledge <= 1'b0;
    end else begin
      engine_reset     <= reset_d;
      master_start     <= start_d;
      data_acknowledge <= dack_d;
    end
  end

  // Line driver and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lin_tx <= 1'b1;
      irq    <= 1'b0;
    end else begin
      lin_tx <= tx_d;
      irq    <= irq_d;
    end
  end

  assign engine_run  = !halted_q;
  assign cfg.master  = link_control_register[CTRL_MASTER_BIT];
  assign cfg.csum    = link_control_register[CTRL_CSUM_BIT];
  assign cfg.dormant = link_control_register[CTRL_DORMANT_BIT];

endmodule // lsw_ctrl

// file: test/lsw_ctrl_properties.sv
// Concurrent checks on the ports of the LIN sleep, wake and error control block.
// Assumes a single aclk domain and the pulse length handed on by the bind.
`timescale 1ns/100ps
module lsw_ctrl_props #(
  parameter int unsigned PULSE_CYC = 10
) (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Bus responses
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // Link and engine
  input wire logic                lin_tx,
  input wire logic                sync_break,
  input wire logic                frame_busy,
  input wire lsw_pkg::lsw_err_in_t err_in,
  input wire lsw_pkg::lsw_cfg_t   cfg,
  input wire logic                engine_run,
  input wire logic                engine_reset,
  input wire logic                master_start
);
  import lsw_pkg::*;
  logic [15:0] low_q;
  // Length of the current low stretch; the sequencer holds the line one cycle past its count
  always_ff @(posedge aclk) begin
    if (!aresetn || lin_tx) low_q <= 16'h0000;
    else low_q <= low_q + 16'h0001;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_halt_holds: assert property (!engine_run && !sync_break |=> !engine_run)
    else $error("halt released without a break");
  a_error_drops: assert property ((err_in.frame_err || err_in.start_bit_err) |-> ##[1:2] engine_reset)
    else $error("error did not drop the frame");
  a_wake_low: assert property ($fell(lin_tx) |-> !lin_tx [*8])
    else $error("wake pulse too short");
  a_wake_length: assert property ($rose(lin_tx) |-> low_q == PULSE_CYC + 1)
    else $error("wake pulse length wrong");
  a_cfg_drops: assert property (frame_busy && ($changed(cfg.csum) || $changed(cfg.master)) |-> ##[0:1] engine_reset)
    else $error("config change kept the transaction");
  a_start_guard: assert property (master_start |-> cfg.master && engine_run)
    else $error("start while slave or halted");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  c_wake_sent: cover property ($rose(lin_tx));
  c_halt_break: cover property (!engine_run ##[1:50] sync_break);
  c_busy_drop: cover property (frame_busy && engine_reset);
endmodule // lsw_ctrl_props

bind lsw_ctrl lsw_ctrl_props #(.PULSE_CYC(PULSE_CYC)) u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .lin_tx, .sync_break, .frame_busy, .err_in, .cfg, .engine_run, .engine_reset,
  .master_start);

// file: test/lsw_node_model.sv
// Another LIN node on the wired-AND bus line behind the transceiver.
// Assumes the bench commands its wake pulses and whether it answers a wake-up.
`timescale 1ns/100ps
module lsw_node_model #(
  parameter int unsigned DLY = 8
) (
  // Clock
  input  wire logic       aclk,
  // Bus line
  input  wire logic       lin_tx,
  output logic            lin_rx,
  // Bench commands
  input  wire logic       answer_en,
  input  wire logic       wake_go,
  input  wire logic [7:0] wake_len,
  // Answer to a slave wake-up
  output logic            master_resp
);
  logic [7:0] low_q = 8'h00;
  logic [7:0] wait_q = 8'h00;
  logic       tx_q = 1'b1;
  initial master_resp = 1'b0;
  // Pull-up line: any node pulling low wins
  assign lin_rx = lin_tx & (low_q == 8'h00);
  always @(posedge aclk) begin
    tx_q <= lin_tx;
    master_resp <= (wait_q == 8'h01);
    if (wake_go) low_q <= wake_len;
    else if (low_q != 8'h00) low_q <= low_q - 8'h01;
    // A silent master is the fault case the slave timeout exists for
    if (answer_en && !tx_q && lin_tx) wait_q <= 8'(DLY);
    else if (wait_q != 8'h00) wait_q <= wait_q - 8'h01;
  end
endmodule // lsw_node_model

// file: test/test_lsw_ctrl.sv
// Self-checking bench for the LIN sleep, wake and error control block.
// Assumes the node model stands on the bus line; the bench plays software and engine.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_lsw_ctrl;
  import lsw_pkg::*;
  localparam int unsigned IDLE = 1000, RESP = 40, PULSE = 10, DET = 5;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, sync_break = 0, frame_busy = 0, answer_en = 0, wake_go = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, wake_len = 8'h0c;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat, m;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  lsw_err_in_t err_in = 2'b00;
  lsw_cfg_t cfg;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lin_rx, lin_tx, master_resp;
  logic engine_run, engine_reset, master_start, data_acknowledge, irq;
  int fails = 0, check_count = 0, n_start = 0, n_dack = 0, n_rst = 0, r0, seed = 32'h64d3b627;
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    n_start <= n_start + master_start;
    n_dack <= n_dack + data_acknowledge;
    n_rst <= n_rst + engine_reset;
  end
  lsw_ctrl #(.IDLE_CYC(IDLE), .RESP_CYC(RESP), .PULSE_CYC(PULSE), .DET_CYC(DET)) uut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lin_rx, .lin_tx, .sync_break, .frame_busy, .master_resp,
    .err_in, .cfg, .engine_run, .engine_reset, .master_start, .data_acknowledge, .irq);
  lsw_node_model #(.DLY(8)) u_node (.aclk, .lin_tx, .lin_rx, .answer_en, .wake_go, .wake_len, .master_resp);
  function automatic logic [31:0] bitv(int b);
    return 32'h1 << b;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    fails++;
    tally_and_finish;
  endtask
  task automatic rd(logic [7:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    fails++;
    tally_and_finish;
  endtask
  task automatic node_wake(logic [7:0] len);
    wake_len <= len;
    wake_go <= 1'b1;
    @(posedge aclk);
    wake_go <= 1'b0;
  endtask
  task automatic st(logic [31:0] e);
    rd(ADDR_STATUS);
    `CHK("status", e, rdat)
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("lin_tx", 1'b1, lin_tx)
    `CHK("run", 1'b1, engine_run)
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      `CHK("reset value", 32'h0, rdat)
    end
    rd(8'h10);
    `CHK("unmapped read", LSW_RESP_SLVERR, resp)
    m = $random(seed);
    wr(8'h14, m);
    `CHK("unmapped write", LSW_RESP_SLVERR, resp)
    wr(ADDR_MASK, m);
    rd(ADDR_MASK);
    `CHK("mask", m & 32'hff, rdat)
    wr(ADDR_MASK, 32'h47);
    $display("test reset and registers done");
    for (int i = 0; i < 2; i++) begin
      err_in <= (i == 0) ? 2'b10 : 2'b01;
      @(posedge aclk);
      err_in <= 2'b00;
      cyc(3);
      `CHK("irq", 1'b1, irq)
      rd(ADDR_ERROR);
      `CHK("error", bitv(i), rdat)
      st(bitv(ST_FAULT_BIT));
      wr(ADDR_CTRL, bitv(CTRL_WAKE_BIT) | bitv(CTRL_MASTER_BIT) | bitv(CTRL_START_BIT));
      cyc(3);
      `CHK("wake refused", 1'b1, lin_tx)
      wr(ADDR_CTRL, bitv(CTRL_CLRERR_BIT));
      rd(ADDR_ERROR);
      `CHK("error cleared", 32'h0, rdat)
      st(32'h0);
    end
    `CHK("start refused", 0, n_start)
    $display("test errors done");
    wr(ADDR_CTRL, bitv(CTRL_MASTER_BIT) | bitv(CTRL_WAKE_BIT));
    cyc(PULSE + 4);
    st(bitv(ST_DONE_BIT));
    `CHK("irq", 1'b1, irq)
    wr(ADDR_STATUS, 32'hff);
    st(32'h0);
    answer_en <= 1'b0;
    wr(ADDR_CTRL, bitv(CTRL_WAKE_BIT));
    cyc(PULSE + 4);
    `CHK("irq", 1'b0, irq)
    cyc(RESP);
    st(bitv(ST_FAULT_BIT));
    rd(ADDR_ERROR);
    `CHK("error", bitv(ERR_RESPONSE_TIMEOUT_ERROR_BIT), rdat)
    wr(ADDR_CTRL, bitv(CTRL_CLRERR_BIT));
    answer_en <= 1'b1;
    wr(ADDR_CTRL, bitv(CTRL_WAKE_BIT));
    cyc(PULSE + RESP + 10);
    st(32'h0);
    $display("test wake send done");
    wr(ADDR_CTRL, bitv(CTRL_DORMANT_BIT));
    `CHK("dormant", 1'b1, cfg.dormant)
    node_wake(8'h0c);
    cyc(20);
    st(bitv(ST_DONE_BIT) | bitv(ST_WAKE_BIT));
    `CHK("irq", 1'b1, irq)
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STATUS, 32'hff);
    $display("test wake detect done");
    wr(ADDR_CTRL, bitv(CTRL_HALT_BIT) | bitv(CTRL_DACK_BIT));
    `CHK("halted", 1'b0, engine_run)
    wr(ADDR_CTRL, bitv(CTRL_MASTER_BIT) | bitv(CTRL_START_BIT));
    `CHK("start while halted", 0, n_start)
    sync_break <= 1'b1;
    @(posedge aclk);
    sync_break <= 1'b0;
    cyc(2);
    `CHK("resumed", 1'b1, engine_run)
    wr(ADDR_CTRL, bitv(CTRL_MASTER_BIT) | bitv(CTRL_START_BIT));
    wr(ADDR_CTRL, bitv(CTRL_MASTER_BIT) | bitv(CTRL_DACK_BIT));
    `CHK("starts", 1, n_start)
    `CHK("acks", 1, n_dack)
    $display("test halt done");
    r0 = n_rst;
    frame_busy <= 1'b1;
    wr(ADDR_CTRL, bitv(CTRL_CSUM_BIT));
    wr(ADDR_CTRL, bitv(CTRL_CSUM_BIT) | bitv(CTRL_MASTER_BIT));
    frame_busy <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    `CHK("engine resets", 2, n_rst - r0)
    $display("test config change done");
    wr(ADDR_CTRL, bitv(CTRL_DORMANT_BIT));
    cyc(IDLE + 100);
    st(32'h0);
    wr(ADDR_CTRL, 32'h0);
    node_wake(8'h02);
    cyc(IDLE - 100);
    node_wake(8'h02);
    cyc(IDLE - 100);
    st(32'h0);
    cyc(200);
    st(bitv(ST_IDLE_BIT));
    `CHK("irq", 1'b1, irq)
    $display("test idle done");
    tally_and_finish;
  end
endmodule // test_lsw_ctrl
